// ---- mch_far_end.sv ----
/*
 * Far-end modem model: answers request to send, sends and takes
 * characters, raises ring. Assumes the bench sets its knobs by name.
 */
`timescale 1ns/10ps
module mch_far_end (
	// Clock and device outputs
	input  wire logic core_clk_i,
	input  wire logic tx_line_i,
	input  wire logic rts_i,
	input  wire logic dtr_i,
	input  wire logic sec_req_i,
	// Line pins toward the device
	output logic      rx_line_o,
	output logic      dsr_o,
	output logic      cd_o,
	output logic      spd_sec_o,
	output logic      ring_o
);
	// ----------
	// Control answers
	// ----------
	int         bit_cyc = 12;
	int         lag     = 9999;
	int         cnt     = 0;
	logic       hdx     = 1'b0;
	logic       dsr_set = 1'b1;
	logic       spd_frc = 1'b0;
	logic [7:0] b;
	logic [7:0] rx_q [$];

	always @(posedge core_clk_i) cnt <= rts_i ? cnt + 1 : 0;
	assign cd_o      = !hdx & rts_i & (cnt >= lag);
	assign spd_sec_o = hdx ? (rts_i & (cnt >= lag)) : spd_frc;
	assign dsr_o     = dsr_set & dtr_i;

	initial begin
		rx_line_o = 1'b1;
		ring_o = 1'b0;
	end

	task automatic ring_once;
		ring_o = 1'b1;
		repeat (5) @(posedge core_clk_i);
		#1 ring_o = 1'b0;
	endtask

	// ----------
	// Character traffic
	// ----------
	task automatic send(input logic [7:0] d);
		logic [9:0] f;
		int         k;
		f = {1'b1, d, 1'b0};
		k = 0;
		while (hdx && !sec_req_i && k < 3000) begin
			@(posedge core_clk_i);
			k++;
		end
		for (int i = 0; i < 10; i++) begin
			@(posedge core_clk_i);
			#1 rx_line_o = f[i];
			repeat (bit_cyc - 1) @(posedge core_clk_i);
		end
	endtask

	initial forever begin
		@(negedge tx_line_i);
		repeat (bit_cyc / 2) @(posedge core_clk_i);
		for (int i = 0; i < 8; i++) begin
			repeat (bit_cyc) @(posedge core_clk_i);
			b[i] = tx_line_i;
		end
		repeat (bit_cyc) @(posedge core_clk_i);
		if (tx_line_i)
			rx_q.push_back(b);
	end
endmodule

// ---- mch_modem_ctrl.sv ----
/*
 * Serial line and modem-control logic of a terminal port.
 * Assumes all pin inputs may change at any time; user-side inputs are
 * synchronous to core_clk_i.
 */
// Operation
// - Send and receive characters serially.
// - Raise request to send, await transmit enable.
// - Ignore clear to send; enable per protocol.
// - Data set ready off ignores inputs but ring.
// - Full duplex uncontrolled forces ready and carrier.
// - Secondary request shows receive readiness.
// - Secondary request off pauses far end.
// - Speed indicator forces 1200 baud.
// - Terminal ready on; off ignores inputs but ring.
// - Ring while off raises terminal ready briefly.
// - Ring while on starts timeout, then pulse.
// - Speed select on at 600 baud or more.
// - One circuit drives secondary request and speed.
// - Shared input is speed or secondary carrier.
`timescale 1ns/10ps
module mch_modem_ctrl #(
	parameter longint unsigned CLK_HZ    = mch_pkg::CLK_HZ,
	parameter int unsigned     RING_CYC  = mch_pkg::RING_CYC,
	parameter int unsigned     PULSE_CYC = mch_pkg::PULSE_CYC,
	parameter int unsigned     RTS_CYC   = mch_pkg::RTS_CYC
) (
	// Clock and reset
	input  wire logic       core_clk_i,
	input  wire logic       rst_n_i,
	// Setup selections
	input  wire logic       half_duplex_i,
	input  wire logic       modem_ctrl_i,
	input  wire logic       sec_chan_i,
	input  wire logic [1:0] txen_sel_i,
	input  wire logic [2:0] baud_sel_i,
	input  wire logic       term_ready_i,
	input  wire logic       rx_ready_i,
	// Character streams
	input  wire logic [7:0] tx_data_i,
	input  wire logic       tx_valid_i,
	output logic            tx_ready_o,
	output logic [7:0]      rx_data_o,
	output logic            rx_valid_o,
	// Line pins
	output logic            serial_tx_line_o,
	input  wire logic       serial_rx_line_i,
	output logic            rts_o,
	input  wire logic       cts_i,
	input  wire logic       dsr_i,
	input  wire logic       carrier_detect_in_i,
	input  wire logic       spd_or_sec_carrier_i,
	input  wire logic       ring_i,
	output logic            dtr_o,
	output logic            secondary_tx_request_out_o,
	output logic            speed_select_out_o
);

	// ----------------------------------------------------------------
	// Input synchronisers and qualification
	// ----------------------------------------------------------------
	logic [4:0]  s1_r, s2_r, raw;
	logic        ring_d_r, dtr_r;
	logic        full, no_ctl, live, cd_q, share_q, spd_q, sec_cd_q;
	logic        rx_line, ring_rise;
	logic [2:0]  baud_idx;
	logic [31:0] div_tab [8];
	logic [31:0] bit_div;

	assign raw = {ring_i, spd_or_sec_carrier_i, carrier_detect_in_i,
		dsr_i, serial_rx_line_i};

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			s1_r     <= mch_pkg::SYNC_RST;
			s2_r     <= mch_pkg::SYNC_RST;
			ring_d_r <= 1'b0;
		end else begin
			s1_r     <= raw;
			s2_r     <= s1_r;
			ring_d_r <= s2_r[4];
		end
	end

	assign full      = !half_duplex_i;
	assign no_ctl    = full & !modem_ctrl_i;
	assign live      = (no_ctl | s2_r[1]) & dtr_r;
	assign cd_q      = no_ctl | (s2_r[2] & live);
	assign share_q   = s2_r[3] & live;
	assign spd_q     = full & share_q;
	assign sec_cd_q  = !full & share_q;
	assign rx_line   = live ? s2_r[0] : 1'b1;
	assign ring_rise = s2_r[4] & !ring_d_r;
	assign baud_idx  = spd_q ? mch_pkg::IDX_1200 : baud_sel_i;

	for (genvar g = 0; g < 8; g++) begin : g_div
		assign div_tab[g] = 32'(CLK_HZ / mch_pkg::BAUD_TAB[g]);
	end
	assign bit_div = div_tab[baud_idx];

	// ----------------------------------------------------------------
	// Transmitter
	// ----------------------------------------------------------------
	mch_pkg::mch_tx_t tx_st_r, tx_st_nxt;
	logic [31:0] tx_cnt_r, tx_cnt_nxt;
	logic [3:0]  tx_bit_r, tx_bit_nxt;
	logic [9:0]  tx_sh_r, tx_sh_nxt;
	logic        txd_r, txd_nxt, rts_r, rts_nxt, txrdy_r, txrdy_nxt;
	logic        txen;

	always_comb begin
		unique case (txen_sel_i)
			mch_pkg::TXEN_CARRIER: txen = cd_q;
			mch_pkg::TXEN_SECOND:  txen = sec_cd_q;
			default: txen = tx_cnt_r >= RTS_CYC - 32'h0000_0001;
		endcase
	end

	always_comb begin
		tx_st_nxt  = tx_st_r;
		tx_cnt_nxt = tx_cnt_r;
		tx_bit_nxt = tx_bit_r;
		tx_sh_nxt  = tx_sh_r;
		txd_nxt    = txd_r;
		rts_nxt    = rts_r;
		txrdy_nxt  = txrdy_r;
		unique case (tx_st_r)
			mch_pkg::TX_IDLE: begin
				if (tx_valid_i && txrdy_r) begin
					tx_sh_nxt  = {1'b1, tx_data_i, 1'b0};
					rts_nxt    = 1'b1;
					txrdy_nxt  = 1'b0;
					tx_cnt_nxt = '0;
					tx_st_nxt  = mch_pkg::TX_WAIT;
				end
			end
			mch_pkg::TX_WAIT: begin
				tx_cnt_nxt = tx_cnt_r + 32'h0000_0001;
				if (txen) begin
					tx_cnt_nxt = '0;
					tx_bit_nxt = '0;
					txd_nxt    = tx_sh_r[0];
					tx_st_nxt  = mch_pkg::TX_SEND;
				end
			end
			mch_pkg::TX_SEND: begin
				tx_cnt_nxt = tx_cnt_r + 32'h0000_0001;
				if (tx_cnt_r >= bit_div - 32'h0000_0001) begin
					tx_cnt_nxt = '0;
					if (tx_bit_r == mch_pkg::LAST_BIT) begin
						txd_nxt   = 1'b1;
						rts_nxt   = 1'b0;
						txrdy_nxt = 1'b1;
						tx_st_nxt = mch_pkg::TX_IDLE;
					end else begin
						tx_bit_nxt = tx_bit_r + 4'h1;
						tx_sh_nxt  = {1'b1, tx_sh_r[9:1]};
						txd_nxt    = tx_sh_r[1];
					end
				end
			end
		endcase
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			tx_st_r  <= mch_pkg::TX_IDLE;
			tx_cnt_r <= '0;
			tx_bit_r <= '0;
			tx_sh_r  <= '1;
			txd_r    <= 1'b1;
			rts_r    <= 1'b0;
			txrdy_r  <= 1'b1;
		end else begin
			tx_st_r  <= tx_st_nxt;
			tx_cnt_r <= tx_cnt_nxt;
			tx_bit_r <= tx_bit_nxt;
			tx_sh_r  <= tx_sh_nxt;
			txd_r    <= txd_nxt;
			rts_r    <= rts_nxt;
			txrdy_r  <= txrdy_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Receiver
	// ----------------------------------------------------------------
	mch_pkg::mch_rx_t rx_st_r, rx_st_nxt;
	logic [31:0] rx_cnt_r, rx_cnt_nxt;
	logic [3:0]  rx_bit_r, rx_bit_nxt;
	logic [7:0]  rx_sh_r, rx_sh_nxt, rxd_r, rxd_nxt;
	logic        rxv_r, rxv_nxt;

	always_comb begin
		rx_st_nxt  = rx_st_r;
		rx_cnt_nxt = rx_cnt_r + 32'h0000_0001;
		rx_bit_nxt = rx_bit_r;
		rx_sh_nxt  = rx_sh_r;
		rxd_nxt    = rxd_r;
		rxv_nxt    = 1'b0;
		unique case (rx_st_r)
			mch_pkg::RX_IDLE: begin
				rx_cnt_nxt = '0;
				if (!rx_line)
					rx_st_nxt = mch_pkg::RX_START;
			end
			mch_pkg::RX_START: begin
				if (rx_cnt_r >= (bit_div >> 1)) begin
					rx_cnt_nxt = '0;
					rx_bit_nxt = '0;
					rx_st_nxt  = rx_line ? mch_pkg::RX_IDLE
						: mch_pkg::RX_DATA;
				end
			end
			mch_pkg::RX_DATA: begin
				if (rx_cnt_r >= bit_div - 32'h0000_0001) begin
					rx_cnt_nxt = '0;
					rx_sh_nxt  = {rx_line, rx_sh_r[7:1]};
					rx_bit_nxt = rx_bit_r + 4'h1;
					if (rx_bit_r == mch_pkg::LAST_DATA)
						rx_st_nxt = mch_pkg::RX_STOP;
				end
			end
			mch_pkg::RX_STOP: begin
				if (rx_cnt_r >= bit_div - 32'h0000_0001) begin
					rx_st_nxt = mch_pkg::RX_IDLE;
					if (rx_line) begin
						rxd_nxt = rx_sh_r;
						rxv_nxt = 1'b1;
					end
				end
			end
		endcase
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			rx_st_r  <= mch_pkg::RX_IDLE;
			rx_cnt_r <= '0;
			rx_bit_r <= '0;
			rx_sh_r  <= '0;
			rxd_r    <= '0;
			rxv_r    <= 1'b0;
		end else begin
			rx_st_r  <= rx_st_nxt;
			rx_cnt_r <= rx_cnt_nxt;
			rx_bit_r <= rx_bit_nxt;
			rx_sh_r  <= rx_sh_nxt;
			rxd_r    <= rxd_nxt;
			rxv_r    <= rxv_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Terminal ready, ring timing and shared output circuit
	// ----------------------------------------------------------------
	mch_pkg::mch_dt_t dt_st_r, dt_st_nxt;
	logic [31:0] tmr_r, tmr_nxt;
	logic        dtr_nxt, shout_r, shout_nxt;

	always_comb begin
		dt_st_nxt = dt_st_r;
		tmr_nxt   = tmr_r + 32'h0000_0001;
		dtr_nxt   = term_ready_i;
		unique case (dt_st_r)
			mch_pkg::DT_IDLE: begin
				tmr_nxt = '0;
				if (ring_rise && !dtr_r) begin
					dtr_nxt   = 1'b1;
					dt_st_nxt = mch_pkg::DT_ANSWER;
				end else if (ring_rise)
					dt_st_nxt = mch_pkg::DT_WATCH;
			end
			mch_pkg::DT_ANSWER: begin
				dtr_nxt = 1'b1;
				if (s2_r[1] || tmr_r >= RING_CYC - 32'h0000_0001) begin
					dtr_nxt   = 1'b0;
					dt_st_nxt = mch_pkg::DT_IDLE;
				end
			end
			mch_pkg::DT_WATCH: begin
				if (rxv_r || !term_ready_i)
					dt_st_nxt = mch_pkg::DT_IDLE;
				else if (tmr_r >= RING_CYC - 32'h0000_0001) begin
					dtr_nxt   = 1'b0;
					tmr_nxt   = '0;
					dt_st_nxt = mch_pkg::DT_PULSE;
				end
			end
			mch_pkg::DT_PULSE: begin
				dtr_nxt = 1'b0;
				if (tmr_r >= PULSE_CYC - 32'h0000_0001) begin
					dtr_nxt   = term_ready_i;
					dt_st_nxt = mch_pkg::DT_IDLE;
				end
			end
		endcase
		if (full)
			shout_nxt = baud_sel_i >= mch_pkg::IDX_600;
		else
			shout_nxt = sec_chan_i & rx_ready_i;
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			dt_st_r <= mch_pkg::DT_IDLE;
			tmr_r   <= '0;
			dtr_r   <= 1'b0;
			shout_r <= 1'b0;
		end else begin
			dt_st_r <= dt_st_nxt;
			tmr_r   <= tmr_nxt;
			dtr_r   <= dtr_nxt;
			shout_r <= shout_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign tx_ready_o                 = txrdy_r;
	assign rx_data_o                  = rxd_r;
	assign rx_valid_o                 = rxv_r;
	assign serial_tx_line_o           = txd_r;
	assign rts_o                      = rts_r;
	assign dtr_o                      = dtr_r;
	assign secondary_tx_request_out_o = shout_r;
	assign speed_select_out_o         = shout_r;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);

	sequence s_watch_expire;
		dt_st_r == mch_pkg::DT_WATCH && !rxv_r && term_ready_i
			&& tmr_r >= RING_CYC - 32'h0000_0001;
	endsequence
	sequence s_pulse_low;
		(!dtr_o && dt_st_r == mch_pkg::DT_PULSE) [*2];
	endsequence

	a_wait_marks: assert property (
		tx_st_r == mch_pkg::TX_WAIT |-> rts_o && serial_tx_line_o)
		else $error("Line left mark state while awaiting enable.");
	a_start_bit: assert property (
		tx_st_r == mch_pkg::TX_WAIT && txen
			|=> !serial_tx_line_o ##0 rts_o)
		else $error("Start bit did not follow transmit enable.");
	a_sec_carrier_hold: assert property (
		tx_st_r == mch_pkg::TX_WAIT && !full && !sec_cd_q
			&& txen_sel_i == mch_pkg::TXEN_SECOND
			|=> tx_st_r == mch_pkg::TX_WAIT)
		else $error("Sent without secondary carrier.");
	a_open_duplex: assert property (
		tx_st_r == mch_pkg::TX_WAIT && no_ctl
			&& txen_sel_i == mch_pkg::TXEN_CARRIER
			|=> tx_st_r == mch_pkg::TX_SEND)
		else $error("Uncontrolled full duplex did not send.");
	a_rx_ignored: assert property (
		rx_st_r == mch_pkg::RX_IDLE && !live
			|=> rx_st_r == mch_pkg::RX_IDLE)
		else $error("Receiver started while inputs ignored.");
	a_rx_pulse: assert property (
		rx_valid_o |=> !rx_valid_o)
		else $error("Receive strobe longer than one cycle.");
	a_speed_sel: assert property (
		full && baud_sel_i >= mch_pkg::IDX_600 |=> speed_select_out_o)
		else $error("Speed select off at high rate.");
	a_ring_answer: assert property (
		dt_st_r == mch_pkg::DT_IDLE && ring_rise && !dtr_o
			|=> dtr_o [*2])
		else $error("Ring did not raise terminal ready.");
	a_answer_drop: assert property (
		dt_st_r == mch_pkg::DT_ANSWER && s2_r[1] |=> !dtr_o)
		else $error("Terminal ready held after data set ready.");
	a_ring_pulse: assert property (
		s_watch_expire |=> s_pulse_low)
		else $error("Ring timeout did not pulse terminal ready.");

endmodule

// ---- mch_pkg.sv ----
/*
 * Constants, state codes and rate table for the modem-control block.
 * Assumes a single 100 MHz core clock; nothing else is required.
 */
package mch_pkg;

	// ----------------------------------------------------------------
	// Clock and times
	// ----------------------------------------------------------------
	localparam longint unsigned CLK_HZ   = 64'h0000_0000_05F5_E100;
	localparam longint unsigned MS_DIV   = 64'h0000_0000_0000_03E8;
	localparam longint unsigned RING_MS  = 64'h0000_0000_0000_7530;
	localparam longint unsigned PULSE_MS = 64'h0000_0000_0000_00E9;
	localparam longint unsigned RTS_MS   = 64'h0000_0000_0000_0032;
	localparam int unsigned RING_CYC  = 32'(RING_MS * (CLK_HZ / MS_DIV));
	localparam int unsigned PULSE_CYC = 32'(PULSE_MS * (CLK_HZ / MS_DIV));
	localparam int unsigned RTS_CYC   = 32'(RTS_MS * (CLK_HZ / MS_DIV));

	// ----------------------------------------------------------------
	// Operator rates, indexed by the rate selection
	// ----------------------------------------------------------------
	localparam int unsigned BAUD_TAB [8] = '{
		32'h0000_006E, 32'h0000_0096, 32'h0000_012C, 32'h0000_0258,
		32'h0000_04B0, 32'h0000_0960, 32'h0000_12C0, 32'h0000_2580
	};
	localparam logic [2:0] IDX_600  = 3'h3;
	localparam logic [2:0] IDX_1200 = 3'h4;

	// ----------------------------------------------------------------
	// Frame, reset values and protocol codes
	// ----------------------------------------------------------------
	localparam logic [3:0] LAST_BIT  = 4'h9;
	localparam logic [3:0] LAST_DATA = 4'h7;
	localparam logic [4:0] SYNC_RST  = 5'h01;
	localparam logic [1:0] TXEN_CARRIER = 2'h0;
	localparam logic [1:0] TXEN_SECOND  = 2'h1;
	localparam logic [1:0] TXEN_TIMEOUT = 2'h2;

	typedef enum logic [2:0] {
		TX_IDLE = 3'b001, TX_WAIT = 3'b010, TX_SEND = 3'b100
	} mch_tx_t;
	typedef enum logic [3:0] {
		RX_IDLE = 4'b0001, RX_START = 4'b0010,
		RX_DATA = 4'b0100, RX_STOP = 4'b1000
	} mch_rx_t;
	typedef enum logic [3:0] {
		DT_IDLE = 4'b0001, DT_ANSWER = 4'b0010,
		DT_WATCH = 4'b0100, DT_PULSE = 4'b1000
	} mch_dt_t;

endpackage

// ---- test_modem_control_handshake.sv ----
/*
 * Self-checking bench for the modem-control block.
 * Assumes the far-end model and shortened timing parameters.
 */
`timescale 1ns/10ps
module test_modem_control_handshake;
	// ----------
	// Signals and instances
	// ----------
	localparam longint unsigned HZ = 64'h0000_0000_0001_D4C0;
	localparam int unsigned RING  = 32'h0000_00C8;
	localparam int unsigned PULSE = 32'h0000_0014;
	localparam int unsigned RTSC  = 32'h0000_000A;
	localparam int BIT   = int'(HZ / mch_pkg::BAUD_TAB[7]);
	localparam int BIT12 = int'(HZ / mch_pkg::BAUD_TAB[mch_pkg::IDX_1200]);
	logic       clk, rst_n, hdx, mctl, sec, term, rxr, txv, cts;
	logic [1:0] txen;
	logic [2:0] baud;
	logic [7:0] txd, rx_data;
	logic       tx_ready, rx_valid, txl, rts, dtr, sreq, sspd;
	logic       rxl, dsr, cd, spd, ring;
	int         error_cnt = 0;
	int         n_checks  = 0;

	mch_modem_ctrl #(.CLK_HZ(HZ), .RING_CYC(RING), .PULSE_CYC(PULSE),
		.RTS_CYC(RTSC)) i_mch_modem_ctrl (
		.core_clk_i(clk), .rst_n_i(rst_n), .half_duplex_i(hdx),
		.modem_ctrl_i(mctl), .sec_chan_i(sec), .txen_sel_i(txen),
		.baud_sel_i(baud), .term_ready_i(term), .rx_ready_i(rxr),
		.tx_data_i(txd), .tx_valid_i(txv), .tx_ready_o(tx_ready),
		.rx_data_o(rx_data), .rx_valid_o(rx_valid),
		.serial_tx_line_o(txl), .serial_rx_line_i(rxl), .rts_o(rts),
		.cts_i(cts), .dsr_i(dsr), .carrier_detect_in_i(cd),
		.spd_or_sec_carrier_i(spd), .ring_i(ring), .dtr_o(dtr),
		.secondary_tx_request_out_o(sreq), .speed_select_out_o(sspd));
	mch_far_end i_mch_far_end (.core_clk_i(clk), .tx_line_i(txl),
		.rts_i(rts), .dtr_i(dtr), .sec_req_i(sreq), .rx_line_o(rxl),
		.dsr_o(dsr), .cd_o(cd), .spd_sec_o(spd), .ring_o(ring));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ----------
	// Shared tasks
	// ----------
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] %s expected %0h seen %0h", nm, e, g);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic give_verdict;
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic setup(input logic h, input logic m,
		input logic [1:0] s, input logic [2:0] r);
		hdx = h;
		i_mch_far_end.hdx = h;
		mctl = m;
		txen = s;
		baud = r;
		cyc(4);
	endtask

	task automatic tx_case(input int hold, input logic [7:0] d);
		logic hi;
		int   k;
		hi = 1'b1;
		i_mch_far_end.rx_q.delete();
		chk("tx ready", 1, tx_ready);
		txd = d;
		txv = 1'b1;
		cyc(1);
		txv = 1'b0;
		cyc(1);
		chk("rts", 1, rts);
		for (k = 0; k < hold; k++) begin
			hi = hi & txl;
			cyc(1);
		end
		chk("hold off", 1, hi);
		k = 0;
		while (i_mch_far_end.rx_q.size() == 0 && k < 2000) begin
			cyc(1);
			k++;
		end
		chk("tx byte", d, i_mch_far_end.rx_q.size() > 0 ?
			i_mch_far_end.rx_q[0] : 32'h0000_0100);
		cyc(BIT);
		chk("rts off", 0, rts);
	endtask

	task automatic rx_case(input logic want, input logic [7:0] d);
		logic       seen;
		logic [7:0] got;
		seen = 1'b0;
		got = 8'h00;
		fork
			i_mch_far_end.send(d);
			repeat (16 * i_mch_far_end.bit_cyc) begin
				@(posedge clk);
				#1;
				if (rx_valid === 1'b1) begin
					seen = 1'b1;
					got = rx_data;
				end
			end
		join
		chk("rx seen", want, seen);
		if (want)
			chk("rx byte", d, got);
		cyc(2);
	endtask

	// ----------
	// Scenarios
	// ----------
	task automatic t_transmit;
		setup(0, 1, mch_pkg::TXEN_CARRIER, 3'h7);
		i_mch_far_end.lag = 40;
		cts = 1'b1;
		tx_case(40, 8'hA5);
		i_mch_far_end.lag = 9999;
		cts = 1'b0;
		setup(0, 1, mch_pkg::TXEN_TIMEOUT, 3'h7);
		tx_case(RTSC - 3, 8'h3C);
		i_mch_far_end.dsr_set = 1'b0;
		setup(0, 0, mch_pkg::TXEN_CARRIER, 3'h7);
		tx_case(0, 8'hC3);
		rx_case(1, 8'h4B);
		i_mch_far_end.dsr_set = 1'b1;
	endtask

	task automatic t_speed;
		for (int r = 0; r < 8; r++) begin
			setup(0, 1, mch_pkg::TXEN_CARRIER, 3'(r));
			chk("spd sel", r >= mch_pkg::IDX_600, sspd);
			chk("sec req", r >= mch_pkg::IDX_600, sreq);
		end
		i_mch_far_end.spd_frc = 1'b1;
		i_mch_far_end.bit_cyc = BIT12;
		cyc(4);
		rx_case(1, 8'h96);
		i_mch_far_end.spd_frc = 1'b0;
		i_mch_far_end.bit_cyc = BIT;
		cyc(4);
	endtask

	task automatic t_half;
		setup(1, 1, mch_pkg::TXEN_SECOND, 3'h7);
		sec = 1'b1;
		rxr = 1'b0;
		cyc(3);
		chk("sec req", 0, sreq);
		fork
			rx_case(1, 8'h5A);
			begin
				cyc(50);
				rxr = 1'b1;
			end
		join
		chk("sec req", 1, sreq);
		i_mch_far_end.lag = 30;
		tx_case(30, 8'h69);
		i_mch_far_end.lag = 9999;
		sec = 1'b0;
		cyc(2);
		chk("sec req", 0, sreq);
	endtask

	task automatic t_ignore;
		setup(0, 1, mch_pkg::TXEN_CARRIER, 3'h7);
		i_mch_far_end.dsr_set = 1'b0;
		cyc(4);
		rx_case(0, 8'h11);
		i_mch_far_end.dsr_set = 1'b1;
		mctl = 1'b0;
		term = 1'b0;
		cyc(4);
		chk("dtr", 0, dtr);
		rx_case(0, 8'h22);
		term = 1'b1;
		cyc(4);
		chk("dtr", 1, dtr);
	endtask

	task automatic t_ring;
		logic hi;
		int   k;
		setup(0, 1, mch_pkg::TXEN_CARRIER, 3'h7);
		term = 1'b0;
		i_mch_far_end.dsr_set = 1'b0;
		cyc(4);
		i_mch_far_end.ring_once();
		cyc(1);
		chk("dtr answer", 1, dtr);
		cyc(RING - 20);
		chk("dtr answer", 1, dtr);
		cyc(30);
		chk("dtr answer end", 0, dtr);
		i_mch_far_end.dsr_set = 1'b1;
		i_mch_far_end.ring_once();
		chk("dtr ring", 1, dtr);
		cyc(6);
		chk("dtr on dsr", 0, dtr);
		term = 1'b1;
		cyc(4);
		i_mch_far_end.ring_once();
		cyc(RING - 20);
		chk("dtr watch", 1, dtr);
		k = 0;
		while (dtr !== 1'b0 && k < 60) begin
			cyc(1);
			k++;
		end
		k = 0;
		while (dtr === 1'b0 && k < 100) begin
			cyc(1);
			k++;
		end
		chk("dtr pulse", PULSE, k);
		cyc(4);
		i_mch_far_end.ring_once();
		rx_case(1, 8'h77);
		hi = 1'b1;
		for (k = 0; k < 120; k++) begin
			hi = hi & dtr;
			cyc(1);
		end
		chk("dtr kept", 1, hi);
	endtask

	// ----------
	// Main sequence
	// ----------
	initial begin
		rst_n = 1'b0;
		hdx = 1'b0;
		mctl = 1'b1;
		sec = 1'b0;
		txen = 2'h0;
		baud = 3'h7;
		term = 1'b1;
		rxr = 1'b1;
		txd = 8'h00;
		txv = 1'b0;
		cts = 1'b0;
		i_mch_far_end.bit_cyc = BIT;
		cyc(20);
		rst_n = 1'b1;
		cyc(3);
		chk("line idle", 1, txl);
		t_transmit;
		t_speed;
		t_half;
		t_ignore;
		t_ring;
		give_verdict;
	end

	initial begin
		#400000;
		error_cnt++;
		give_verdict;
	end
endmodule
